//--- design/ocpwm_pkg.sv
package ocpwm_pkg;
  // ==========================================================================
  // Register map, byte addresses of aligned 32-bit words.
  localparam logic [4:0] ADDR_CTRL1 = 5'h00;
  localparam logic [4:0] ADDR_CTRL2 = 5'h04;
  localparam logic [4:0] ADDR_PRI = 5'h08;
  localparam logic [4:0] ADDR_SEC = 5'h0C;
  localparam logic [4:0] ADDR_TB = 5'h10;
  localparam logic [4:0] ADDR_STAT = 5'h14;
  // ==========================================================================
  // Field positions.
  localparam int C1_PRE_BIT = 3;
  localparam int C1_FEN_BIT = 4;
  localparam int C2_DCB_LO = 9;
  localparam int ST_FLT_BIT = 0;
  localparam int ST_LVL_BIT = 1;
  // ==========================================================================
  // Reset values.
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam logic [15:0] CTRL2_RST = 16'h0000;
  localparam logic [15:0] VAL_RST = 16'h0000;
  // ==========================================================================
  // Compare mode encodings.
  localparam logic [2:0] M_OFF = 3'h0;
  localparam logic [2:0] M_SS_HI = 3'h1;
  localparam logic [2:0] M_SS_LO = 3'h2;
  localparam logic [2:0] M_TOG = 3'h3;
  localparam logic [2:0] M_DBL_ONE = 3'h4;
  localparam logic [2:0] M_DBL_RUN = 3'h5;
  localparam logic [2:0] M_PWM_EDGE = 3'h6;
  localparam logic [2:0] M_PWM_CTR = 3'h7;
  // ==========================================================================
  // Timing: one instruction cycle spans four system clocks.
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [2:0] PRE_LAST = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Progress of the one-shot and double compare sequences.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WPRI = 4'b0010,
    ST_WSEC = 4'b0100,
    ST_DONE = 4'b1000
  } ocpwm_st_t;
endpackage : ocpwm_pkg

//--- design/ocpwm_top.sv
// What this block does
// R1 - Two-bit falling-edge delay field sits in control two at bits 10:9.
// R2 - Delay value 10 puts the falling edge halfway through the match cycle.
// R3 - Software must not use the delay field in mode 001.
// R4 - In both PWM modes the delay field is double-buffered per period.
// R5 - The delay counts system clocks even when the prescaler is on.
// R6 - Delay feature is meant for a channel clocked from the system clock.
// R7 - Mode 111 produces center-aligned PWM on the output pin.
// R8 - Mode 110 produces edge-aligned PWM on the output pin.
// R9 - Mode 101 starts low, toggles on alternate primary/secondary matches, forever.
// R10 - Mode 100 starts low, toggles on primary then secondary match, one pulse.
// R11 - Mode 011 toggles the output on every compare event.
// R12 - Mode 010 starts high and drops low once on the compare event.
// R13 - Mode 001 starts low and rises once on the compare event.
// R14 - Mode 000 disables the channel with no compare activity.
// R15 - Fault comparator: channels 1-2 use 1, 3-4 use 2, 5 uses 3.
// R16 - Edge PWM: high at period start, low at duty match, period from secondary.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
module ocpwm_top #(
  parameter int CHAN_NUM = 1
) (
  input wire logic CLK_SYS, // System clock, 250 MHz.
  input wire logic RST_B, // Asynchronous reset, active low.
  input wire logic [2:0] CMP_IN, // Analog comparator outputs 1..3.
  output logic COMPARE_OUT, // Compare output pin.
  input wire logic [4:0] S_AXI_AWADDR, // Write address.
  input wire logic S_AXI_AWVALID, // Write address valid.
  output logic S_AXI_AWREADY, // Write address ready.
  input wire logic [31:0] S_AXI_WDATA, // Write data.
  input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
  input wire logic S_AXI_WVALID, // Write data valid.
  output logic S_AXI_WREADY, // Write data ready.
  output logic [1:0] S_AXI_BRESP, // Write response.
  output logic S_AXI_BVALID, // Write response valid.
  input wire logic S_AXI_BREADY, // Write response ready.
  input wire logic [4:0] S_AXI_ARADDR, // Read address.
  input wire logic S_AXI_ARVALID, // Read address valid.
  output logic S_AXI_ARREADY, // Read address ready.
  output logic [31:0] S_AXI_RDATA, // Read data.
  output logic [1:0] S_AXI_RRESP, // Read response.
  output logic S_AXI_RVALID, // Read data valid.
  input wire logic S_AXI_RREADY // Read data ready.
);
  // ==========================================================================
  // Bus slave: address and data are latched separately, written together.
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [4:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [15:0] ctrl1_r, ctrl2_r, pri_r, sec_r;
  logic flt_flag_r;
  wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID && S_AXI_WREADY;
  wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  wire do_wr = aw_got_r && w_got_r && !bvalid_r;
  wire wr_c1 = do_wr && awaddr_r == ocpwm_pkg::ADDR_CTRL1;
  wire wr_c2 = do_wr && awaddr_r == ocpwm_pkg::ADDR_CTRL2;
  wire wr_pri = do_wr && awaddr_r == ocpwm_pkg::ADDR_PRI;
  wire wr_sec = do_wr && awaddr_r == ocpwm_pkg::ADDR_SEC;
  wire wr_st = do_wr && awaddr_r == ocpwm_pkg::ADDR_STAT;
  wire wr_ok = wr_c1 || wr_c2 || wr_pri || wr_sec || wr_st
    || awaddr_r == ocpwm_pkg::ADDR_TB;
  assign S_AXI_AWREADY = !aw_got_r && !bvalid_r;
  assign S_AXI_WREADY = !w_got_r && !bvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // Byte-lane merge: only the low two lanes hold register bits.
  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = {wstrb_r[1] ? wdata_r[15:8] : old[15:8],
             wstrb_r[0] ? wdata_r[7:0] : old[7:0]};
  endfunction : merge

  // Handshake state of the write channel.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= ocpwm_pkg::RESP_OKAY;
      awaddr_r <= 5'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {S_AXI_AWADDR[4:2], 2'b00};
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA;
        wstrb_r <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? ocpwm_pkg::RESP_OKAY : ocpwm_pkg::RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Instruction-cycle phase and prescaler; tick advances the timebase.
  logic [1:0] phase_r;
  logic [2:0] pre_r;
  wire [2:0] mode = ctrl1_r[2:0];
  wire pre_en = ctrl1_r[ocpwm_pkg::C1_PRE_BIT];
  wire instr_end = phase_r == ocpwm_pkg::PHASE_LAST;
  wire tick = instr_end && (!pre_en || pre_r == ocpwm_pkg::PRE_LAST);
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      phase_r <= 2'h0;
      pre_r <= 3'h0;
    end else begin
      phase_r <= phase_r + 2'h1;
      if (instr_end) pre_r <= pre_en ? pre_r + 3'h1 : 3'h0;
    end
  end

  // ==========================================================================
  // Fault input: the selected comparator is chosen after synchronising.
  localparam int FSEL = (CHAN_NUM <= 2) ? 0 : (CHAN_NUM <= 4) ? 1 : 2;
  logic [2:0] cmp_s1_r, cmp_s2_r;
  wire pwm_mode = mode == ocpwm_pkg::M_PWM_EDGE || mode == ocpwm_pkg::M_PWM_CTR;
  wire flt_hit = cmp_s2_r[FSEL] && ctrl1_r[ocpwm_pkg::C1_FEN_BIT] && pwm_mode; // R15
  wire flt_block = flt_flag_r && pwm_mode;

  // ==========================================================================
  // Timebase, direction and compare events.
  logic [15:0] tb_r, tb_nxt;
  logic dir_r, dir_nxt;
  wire ev_pri = tick && tb_r == pri_r;
  wire ev_sec = tick && tb_r == sec_r;
  wire wraps = mode == ocpwm_pkg::M_DBL_ONE || mode == ocpwm_pkg::M_DBL_RUN
    || mode == ocpwm_pkg::M_PWM_EDGE;
  wire upd = tick && ((mode == ocpwm_pkg::M_PWM_EDGE && tb_r == sec_r)
    || (mode == ocpwm_pkg::M_PWM_CTR && !dir_r && tb_r == 16'h0000));

  // Center mode counts up to the secondary value and back down to zero.
  always_comb begin
    tb_nxt = tb_r;
    dir_nxt = dir_r;
    if (mode == ocpwm_pkg::M_OFF || wr_c1) begin
      tb_nxt = 16'h0000; // R14
      dir_nxt = 1'b1;
    end else if (tick && mode == ocpwm_pkg::M_PWM_CTR) begin
      if (dir_r && tb_r >= sec_r) begin
        dir_nxt = 1'b0;
        tb_nxt = (tb_r == 16'h0000) ? 16'h0000 : tb_r - 16'h0001;
      end else if (!dir_r && tb_r == 16'h0000) begin
        dir_nxt = 1'b1;
        tb_nxt = (sec_r == 16'h0000) ? 16'h0000 : 16'h0001;
      end else begin
        tb_nxt = dir_r ? tb_r + 16'h0001 : tb_r - 16'h0001;
      end
    end else if (tick) begin
      tb_nxt = (wraps && tb_r == sec_r) ? 16'h0000 : tb_r + 16'h0001; // R16
    end
  end

  // ==========================================================================
  // Waveform level per mode; the pin follows with the falling-edge delay.
  ocpwm_pkg::ocpwm_st_t st_r, st_nxt;
  logic lvl_r, lvl_nxt;
  always_comb begin
    st_nxt = st_r;
    lvl_nxt = lvl_r;
    if (wr_c1) begin
      st_nxt = ocpwm_pkg::ST_WPRI;
      lvl_nxt = wdata_r[2:0] == ocpwm_pkg::M_SS_LO; // R12 R13 R10 R9
    end else begin
      case (mode)
        ocpwm_pkg::M_SS_HI: if (st_r == ocpwm_pkg::ST_WPRI && ev_pri) begin
          lvl_nxt = 1'b1; // R13
          st_nxt = ocpwm_pkg::ST_DONE;
        end
        ocpwm_pkg::M_SS_LO: if (st_r == ocpwm_pkg::ST_WPRI && ev_pri) begin
          lvl_nxt = 1'b0; // R12
          st_nxt = ocpwm_pkg::ST_DONE;
        end
        ocpwm_pkg::M_TOG: if (ev_pri) lvl_nxt = !lvl_r; // R11
        ocpwm_pkg::M_DBL_ONE, ocpwm_pkg::M_DBL_RUN: begin
          if (st_r == ocpwm_pkg::ST_WPRI && ev_pri) begin
            lvl_nxt = 1'b1;
            st_nxt = ocpwm_pkg::ST_WSEC;
          end else if (st_r == ocpwm_pkg::ST_WSEC && ev_sec) begin
            lvl_nxt = 1'b0; // R10 R9
            st_nxt = (mode == ocpwm_pkg::M_DBL_RUN) ? ocpwm_pkg::ST_WPRI
              : ocpwm_pkg::ST_DONE;
          end
        end
        ocpwm_pkg::M_PWM_EDGE: begin
          if (flt_block) lvl_nxt = 1'b0;
          else if (ev_pri) lvl_nxt = 1'b0; // R8 R16
          else if (tick && tb_r == 16'h0000) lvl_nxt = 1'b1;
        end
        ocpwm_pkg::M_PWM_CTR: begin
          if (flt_block) lvl_nxt = 1'b0;
          else if (tick) lvl_nxt = tb_r < pri_r; // R7
        end
        default: begin
          lvl_nxt = 1'b0; // R14
          st_nxt = ocpwm_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Delay field is buffered at the period boundary in PWM, direct otherwise.
  logic [1:0] dcb_r, dly_r;
  logic out_r;
  wire [1:0] dcb_fld = ctrl2_r[ocpwm_pkg::C2_DCB_LO +: 2]; // R1
  wire [1:0] dcb_use = (mode == ocpwm_pkg::M_SS_HI) ? 2'h0 : dcb_r; // R3 R6
  assign COMPARE_OUT = out_r;

  // Rising edges pass after one clock; falling edges wait dcb_use more
  // system clocks, so a quarter instruction cycle per step whatever the
  // prescaler does.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      tb_r <= ocpwm_pkg::VAL_RST;
      dir_r <= 1'b1;
      st_r <= ocpwm_pkg::ST_IDLE;
      lvl_r <= 1'b0;
      dcb_r <= 2'h0;
      dly_r <= 2'h0;
      out_r <= 1'b0;
      cmp_s1_r <= 3'h0;
      cmp_s2_r <= 3'h0;
    end else begin
      tb_r <= tb_nxt;
      dir_r <= dir_nxt;
      st_r <= st_nxt;
      lvl_r <= lvl_nxt;
      cmp_s1_r <= CMP_IN;
      cmp_s2_r <= cmp_s1_r;
      if (!pwm_mode || upd) dcb_r <= dcb_fld; // R4
      if (lvl_r) begin
        out_r <= 1'b1;
        dly_r <= 2'h0;
      end else if (out_r) begin
        if (dly_r == dcb_use) out_r <= 1'b0; // R2 R5
        else dly_r <= dly_r + 2'h1;
      end else begin
        dly_r <= 2'h0;
      end
    end
  end

  // ==========================================================================
  // Register file; the fault flag set wins over a clearing write.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ctrl1_r <= ocpwm_pkg::CTRL1_RST;
      ctrl2_r <= ocpwm_pkg::CTRL2_RST;
      pri_r <= ocpwm_pkg::VAL_RST;
      sec_r <= ocpwm_pkg::VAL_RST;
      flt_flag_r <= 1'b0;
    end else begin
      if (wr_c1) ctrl1_r <= merge(ctrl1_r);
      if (wr_c2) ctrl2_r <= merge(ctrl2_r);
      if (wr_pri) pri_r <= merge(pri_r);
      if (wr_sec) sec_r <= merge(sec_r);
      if (flt_hit) flt_flag_r <= 1'b1;
      else if (wr_st && wstrb_r[0] && wdata_r[ocpwm_pkg::ST_FLT_BIT]) flt_flag_r <= 1'b0;
    end
  end

  // Read path; unmapped addresses answer SLVERR with zero data.
  wire [4:0] ra = {S_AXI_ARADDR[4:2], 2'b00};
  wire [15:0] stat = {10'h000, st_r, lvl_r, flt_flag_r};
  wire rd_ok = ra <= ocpwm_pkg::ADDR_STAT;
  wire [15:0] rsel = (ra == ocpwm_pkg::ADDR_CTRL1) ? ctrl1_r
    : (ra == ocpwm_pkg::ADDR_CTRL2) ? ctrl2_r
    : (ra == ocpwm_pkg::ADDR_PRI) ? pri_r
    : (ra == ocpwm_pkg::ADDR_SEC) ? sec_r
    : (ra == ocpwm_pkg::ADDR_TB) ? tb_r
    : (ra == ocpwm_pkg::ADDR_STAT) ? stat : 16'h0000;
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ocpwm_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rsel};
      rresp_r <= rd_ok ? ocpwm_pkg::RESP_OKAY : ocpwm_pkg::RESP_SLVERR;
    end else if (rvalid_r && S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks on the waveform engine.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  // Five cycles let the longest falling-edge delay drain before the pin must be low.
  a_off_stays_low: assert property ((mode == ocpwm_pkg::M_OFF)[*5] |-> !out_r) // R14
    else $error("output not low while disabled");
  a_ss_rise_once: assert property ((mode == ocpwm_pkg::M_SS_HI && !wr_c1 // R13
    && st_r == ocpwm_pkg::ST_WPRI && ev_pri) |-> ##2 out_r)
    else $error("single-shot high did not rise");
  a_ss_low_no_rise: assert property ((mode == ocpwm_pkg::M_SS_LO && !$past(wr_c1)) // R12
    |-> !$rose(lvl_r)) else $error("single-shot low rose");
  a_toggle_event: assert property ((mode == ocpwm_pkg::M_TOG && ev_pri && !wr_c1) // R11
    |=> lvl_r != $past(lvl_r)) else $error("toggle missed");
  a_dbl_sec_low: assert property ((st_r == ocpwm_pkg::ST_WSEC && ev_sec && !wr_c1) // R10
    |=> !lvl_r) else $error("secondary match did not end pulse");
  a_dbl_run_rearm: assert property ((mode == ocpwm_pkg::M_DBL_RUN // R9
    && st_r == ocpwm_pkg::ST_WSEC && ev_sec && !wr_c1) |=> st_r == ocpwm_pkg::ST_WPRI)
    else $error("continuous mode did not re-arm");
  a_edge_period_high: assert property ((mode == ocpwm_pkg::M_PWM_EDGE && tick // R8
    && tb_r == 16'h0000 && pri_r != 16'h0000 && !flt_block && !wr_c1) |=> lvl_r)
    else $error("edge PWM not high at period start");
  a_center_level: assert property ((mode == ocpwm_pkg::M_PWM_CTR && tick // R7
    && !flt_block && !wr_c1) |=> lvl_r == ($past(tb_r) < $past(pri_r)))
    else $error("center PWM level wrong");
  a_half_delay: assert property (($fell(lvl_r) && dcb_use == 2'h2) // R2
    |-> out_r[*3] ##1 !out_r) else $error("half-cycle falling edge misplaced");
  a_dcb_buffered: assert property ((pwm_mode && !upd && !$past(wr_c1)) // R4
    |=> $stable(dcb_r)) else $error("delay field changed mid-period");

  c_edge_pwm: cover property (mode == ocpwm_pkg::M_PWM_EDGE && $fell(out_r));
  c_center_pwm: cover property (mode == ocpwm_pkg::M_PWM_CTR && $rose(out_r));
  c_one_pulse: cover property (mode == ocpwm_pkg::M_DBL_ONE && st_r == ocpwm_pkg::ST_DONE);
  c_fault: cover property (flt_hit);
endmodule : ocpwm_top

//--- tb/ocpwm_load_model.sv
// ============================================================
// Passive load on the compare pin: counts pulses and times them.
module ocpwm_load_model (
  input wire logic clk, // System clock.
  input wire logic rst_b, // Reset, active low.
  input wire logic pin, // Compare output pin.
  input wire logic clr, // Clears the pulse count.
  output int n_rise, // Rising edges seen since the last clear.
  output int hi_len, // Clocks of the last complete high pulse.
  output int per_len // Clocks between the last two rising edges.
);
  timeunit 1ns;
  timeprecision 1ps;
  int hc;
  int pc;
  logic pin_d;
  // Timing is done in whole clocks, so sub-cycle delays show up as extra clocks.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      n_rise <= 0;
      hi_len <= 0;
      per_len <= 0;
      hc <= 0;
      pc <= 0;
      pin_d <= 1'b0;
    end else begin
      pin_d <= pin;
      pc <= pc + 1;
      if (pin) hc <= pin_d ? hc + 1 : 1;
      if (!pin && pin_d) hi_len <= hc;
      if (pin && !pin_d) begin
        n_rise <= clr ? 0 : n_rise + 1;
        per_len <= pc;
        pc <= 1;
      end else if (clr) begin
        n_rise <= 0;
      end
    end
  end
endmodule : ocpwm_load_model

//--- tb/test_output_compare_pwm.sv
// ============================================================
// Bench: register traffic over AXI4-Lite, pin watched by the load model.
module test_output_compare_pwm;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, awv, wv, bready, arv, rready, clr;
  logic [2:0] cmp;
  logic [4:0] awa, ara;
  logic [31:0] wd, d;
  logic [3:0] ws;
  wire logic pin, awr, wrdy, bv, arr, rv;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  int n_fail, check_count, n_rise, hi_len, per_len;
  ocpwm_top #(.CHAN_NUM(1)) dut (.CLK_SYS(clk), .RST_B(rst_b), .CMP_IN(cmp),
    .COMPARE_OUT(pin), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rready));
  ocpwm_load_model load (.clk(clk), .rst_b(rst_b), .pin(pin), .clr(clr),
    .n_rise(n_rise), .hi_len(hi_len), .per_len(per_len));
  // ============================================================
  // Clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ============================================================
  // Report and checking helpers.
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tmo;
    n_fail++;
    $display("[FAIL] t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
    conclude();
  endtask : tmo
  // Handshakes are sampled mid-cycle, where the combinational readies have settled.
  // The response readies stay high between calls, so a call that follows at once
  // never drops and raises them again within one time step.
  task automatic axw(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
    int i;
    logic ta, tw, bt;
    logic [1:0] r;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    bt = 1'b0;
    for (i = 0; i < 40 && !bt; i++) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      bt = bv;
      r = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    if (!bt) tmo();
    chk({30'h0, r}, {30'h0, er});
  endtask : axw
  task automatic axr(input logic [4:0] a, output logic [31:0] v, input logic [1:0] er);
    int i;
    logic ta, got;
    logic [1:0] r;
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    got = 1'b0;
    for (i = 0; i < 40 && !got; i++) begin
      @(negedge clk);
      ta = arv && arr;
      got = rv;
      r = rr;
      v = rd;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
    if (!got) tmo();
    chk({30'h0, r}, {30'h0, er});
  endtask : axr
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    axw(a, v, ocpwm_pkg::RESP_OKAY);
  endtask : wr
  task automatic md(input logic [2:0] m);
    wr(ocpwm_pkg::ADDR_CTRL1, {29'h0, m});
  endtask : md
  task automatic wait_pin(input logic v);
    int i;
    for (i = 0; i < 2000 && pin !== v; i++) @(negedge clk);
    if (pin !== v) tmo();
    @(posedge clk);
  endtask : wait_pin
  task automatic clear;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : clear
  // ============================================================
  // Main sequence: registers, then every compare mode in turn.
  initial begin
    rst_b = 1'b0;
    {cmp, clr, awv, wv, arv, bready, rready, awa, ara, wd} = '0;
    ws = 4'hF;
    n_fail = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axr(ocpwm_pkg::ADDR_CTRL1, d, ocpwm_pkg::RESP_OKAY);
    chk(d, {16'h0, ocpwm_pkg::CTRL1_RST});
    axr(ocpwm_pkg::ADDR_CTRL2, d, ocpwm_pkg::RESP_OKAY);
    chk(d, {16'h0, ocpwm_pkg::CTRL2_RST});
    axr(5'h18, d, ocpwm_pkg::RESP_SLVERR);
    chk(d, 32'h0);
    axw(5'h18, 32'h0000FFFF, ocpwm_pkg::RESP_SLVERR);
    wr(ocpwm_pkg::ADDR_PRI, 32'h00001234);
    axr(ocpwm_pkg::ADDR_PRI, d, ocpwm_pkg::RESP_OKAY);
    chk(d, 32'h00001234);
    wr(ocpwm_pkg::ADDR_PRI, 32'h2);
    wr(ocpwm_pkg::ADDR_SEC, 32'h7);
    wr(ocpwm_pkg::ADDR_CTRL2, 32'h0);
    md(ocpwm_pkg::M_OFF);
    clear();
    repeat (100) @(posedge clk);
    chk(n_rise, 0);
    md(ocpwm_pkg::M_SS_HI);
    wait_pin(1'b1);
    clear();
    repeat (200) @(posedge clk);
    chk({31'h0, pin}, 32'h1);
    chk(n_rise, 0);
    md(ocpwm_pkg::M_OFF);
    md(ocpwm_pkg::M_SS_LO);
    wait_pin(1'b1);
    wait_pin(1'b0);
    repeat (200) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
    md(ocpwm_pkg::M_TOG);
    wait_pin(1'b1);
    // Double compare: toggles at 2 and 5, period of six ticks of four clocks.
    wr(ocpwm_pkg::ADDR_SEC, 32'h5);
    md(ocpwm_pkg::M_OFF);
    clear();
    md(ocpwm_pkg::M_DBL_ONE);
    repeat (150) @(posedge clk);
    chk(n_rise, 1);
    chk(hi_len, 12);
    md(ocpwm_pkg::M_DBL_RUN);
    clear();
    repeat (150) @(posedge clk);
    chk({31'h0, n_rise > 3}, 32'h1);
    chk(hi_len, 12);
    chk(per_len, 24);
    // Edge PWM, duty 2 of 8 ticks, falling edge held two system clocks.
    wr(ocpwm_pkg::ADDR_SEC, 32'h7);
    wr(ocpwm_pkg::ADDR_CTRL2, 32'h00000400);
    md(ocpwm_pkg::M_PWM_EDGE);
    repeat (80) @(posedge clk);
    chk(hi_len, 10);
    chk(per_len, 32);
    wait_pin(1'b1);
    wr(ocpwm_pkg::ADDR_CTRL2, 32'h0);
    wait_pin(1'b0);
    repeat (2) @(posedge clk);
    chk(hi_len, 10);
    repeat (64) @(posedge clk);
    chk(hi_len, 8);
    // Prescaler stretches ticks to 32 clocks but not the delay.
    wr(ocpwm_pkg::ADDR_CTRL2, 32'h00000400);
    wr(ocpwm_pkg::ADDR_CTRL1, 32'h0000000E);
    repeat (600) @(posedge clk);
    chk(hi_len, 66);
    chk(per_len, 256);
    wr(ocpwm_pkg::ADDR_CTRL2, 32'h0);
    md(ocpwm_pkg::M_PWM_CTR);
    repeat (150) @(posedge clk);
    chk(per_len, 56);
    // Fault: only comparator one serves channel one.
    wr(ocpwm_pkg::ADDR_CTRL1, 32'h00000016);
    cmp <= 3'b110;
    repeat (40) @(posedge clk);
    axr(ocpwm_pkg::ADDR_STAT, d, ocpwm_pkg::RESP_OKAY);
    chk(d & 32'h1, 32'h0);
    cmp <= 3'b001;
    repeat (10) @(posedge clk);
    axr(ocpwm_pkg::ADDR_STAT, d, ocpwm_pkg::RESP_OKAY);
    chk(d & 32'h1, 32'h1);
    clear();
    cmp <= 3'b000;
    repeat (80) @(posedge clk);
    chk(n_rise, 0);
    wr(ocpwm_pkg::ADDR_STAT, 32'h1);
    repeat (80) @(posedge clk);
    chk({31'h0, n_rise > 0}, 32'h1);
    conclude();
  end
endmodule : test_output_compare_pwm
